// file: include/spi_pins_pkg.sv
// Shared constants and types for the serial data and select pin block.
`default_nettype none

package spi_pins_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned LINK_HALF_NS   = 400;
  // Least half period of the serial clock, rounded up to whole cycles.
  localparam int unsigned HALF_CYCLES    =
    (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned WORD_BITS      = 8;
  localparam int unsigned FIFO_DEPTH     = 4;
  localparam int unsigned PIN_COUNT      = 3;

  // Pin index within the three shared lines.
  localparam int unsigned PIN_MOSI       = 0;
  localparam int unsigned PIN_MISO       = 1;
  localparam int unsigned PIN_SS         = 2;

  // Pull-up enable bit positions in the port E pull-up vector.
  localparam int unsigned PU_BIT_MOSI    = 5;
  localparam int unsigned PU_BIT_MISO    = 6;
  localparam int unsigned PU_BIT_SS      = 7;

  localparam logic [2:0] FUNC_SEL_RESET  = 3'h0;
  localparam logic [2:0] PULLUP_RESET    = 3'h7;
  localparam logic [7:0] IDLE_FILL       = 8'hFF;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SETUP = 2'h1,
    ST_HOLD  = 2'h3
  } xfer_state_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_word_t;

endpackage

`default_nettype wire

// file: src/pin_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs.
`default_nettype none

module pin_sync
  import spi_pins_pkg::*;
#(
  parameter int unsigned WIDTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

`default_nettype wire

// file: src/word_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`default_nettype none

module word_fifo
  import spi_pins_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push)
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
    if (pop)
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
    if (push && !pop)
      cnt_next = cnt_reg + (AW+1)'(1);
    else if (pop && !push)
      cnt_next = cnt_reg - (AW+1)'(1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage carries no reset; only the pointers define its contents.
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end

endmodule

`default_nettype wire

// file: src/spi_data_select_pins.sv
// Data and select pins of serial port 0 with shared port E line logic.
// Summary of operation
// - Master drives master-out; slave only reads it.
// - Master-out bit leads sampling edge by half.
// - Master reads master-in; selected slave drives it.
// - Unselected slave floats its master-in output.
// - Slave master-in bit follows falling edge by four clocks.
// - Low slave select frames the received transfer.
// - Pins come up in serial function after reset.
// - Port lines individually programmable input or output.
// - Pull-up bits 5, 6, 7 gate pin pull-ups.
`default_nettype none

module spi_data_select_pins
  import spi_pins_pkg::*;
#(
  parameter int unsigned WIDTH       = WORD_BITS,
  parameter int unsigned DEPTH       = FIFO_DEPTH,
  parameter int unsigned HALF_PERIOD = HALF_CYCLES
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             master_mode,
  input  wire logic             sclk_in,
  output logic                  sclk_out,
  input  wire logic             port0_master_out_data_in,
  output pin_drive_t            port0_master_out_data_drv,
  input  wire logic             port0_master_in_data_in,
  output pin_drive_t            port0_master_in_data_drv,
  input  wire logic             port0_slave_select_n_in,
  output pin_drive_t            port0_slave_select_n_drv,
  output logic      [2:0]       pin_pullup_on,
  input  wire logic [7:0]       port_e_pullup_enable,
  input  wire logic [2:0]       pin_func_is_port,
  input  wire logic [2:0]       port_line_dir_out,
  input  wire logic [2:0]       port_line_out,
  output logic      [2:0]       port_line_in,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  input  wire logic [WIDTH-1:0] tx_data,
  output rx_word_t              rx_word,
  output logic                  busy
);

  localparam int unsigned DW = $clog2(HALF_PERIOD + 1);
  localparam int unsigned BW = $clog2(WIDTH);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and serial clock edge detection.

  logic [3:0] pins_sync;
  logic       mosi_s;
  logic       miso_s;
  logic       ss_n_s;
  logic       sclk_s;
  logic       sclk_last_reg;
  logic       sclk_last_next;
  logic       sclk_rise;
  logic       sclk_fall;

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({sclk_in, port0_slave_select_n_in,
                port0_master_in_data_in, port0_master_out_data_in}),
    .sync_out (pins_sync)
  );

  assign mosi_s         = pins_sync[0];
  assign miso_s         = pins_sync[1];
  assign ss_n_s         = pins_sync[2];
  assign sclk_s         = pins_sync[3];
  assign sclk_last_next = sclk_s;
  assign sclk_rise      = sclk_s && !sclk_last_reg;
  assign sclk_fall      = !sclk_s && sclk_last_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO.

  logic             fifo_valid;
  logic             fifo_pop;
  logic [WIDTH-1:0] fifo_data;

  word_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Function select and pull-up control.

  logic [2:0] func_port_reg;
  logic [2:0] func_port_next;
  logic [2:0] pullup_reg;
  logic [2:0] pullup_next;
  logic       serial_mosi;
  logic       serial_miso;
  logic       serial_ss;
  logic       slave_selected;

  always_comb
  begin
    func_port_next = pin_func_is_port;
    pullup_next    = {port_e_pullup_enable[PU_BIT_SS],
                      port_e_pullup_enable[PU_BIT_MISO],
                      port_e_pullup_enable[PU_BIT_MOSI]};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      func_port_reg <= FUNC_SEL_RESET;
      pullup_reg    <= PULLUP_RESET;
      sclk_last_reg <= 1'b0;
    end
    else
    begin
      func_port_reg <= func_port_next;
      pullup_reg    <= pullup_next;
      sclk_last_reg <= sclk_last_next;
    end
  end

  assign pin_pullup_on  = pullup_reg;
  assign serial_mosi    = !func_port_reg[PIN_MOSI];
  assign serial_miso    = !func_port_reg[PIN_MISO];
  assign serial_ss      = !func_port_reg[PIN_SS];
  // A slave only answers while its select pin is serial and held low.
  assign slave_selected = !master_mode && serial_ss && !ss_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine: mode 0, sample on rising edge, launch on falling.

  xfer_state_t      state_reg;
  xfer_state_t      state_next;
  logic [DW-1:0]    div_reg;
  logic [DW-1:0]    div_next;
  logic [BW-1:0]    bit_reg;
  logic [BW-1:0]    bit_next;
  logic [WIDTH-1:0] tx_sh_reg;
  logic [WIDTH-1:0] tx_sh_next;
  logic [WIDTH-1:0] rx_sh_reg;
  logic [WIDTH-1:0] rx_sh_next;
  logic             sclk_reg;
  logic             sclk_next;
  logic             sclk_dly_reg;
  logic             sclk_dly_next;
  rx_word_t         rx_reg;
  rx_word_t         rx_next;
  logic             half_done;
  logic [WIDTH-1:0] load_word;

  assign half_done = (div_reg == DW'(HALF_PERIOD - 1));
  assign load_word = fifo_valid ? fifo_data : WIDTH'(IDLE_FILL);

  always_comb
  begin
    state_next = state_reg;
    div_next   = div_reg;
    bit_next   = bit_reg;
    tx_sh_next = tx_sh_reg;
    rx_sh_next = rx_sh_reg;
    sclk_next  = sclk_reg;
    rx_next    = '{valid: 1'b0, data: rx_reg.data};
    fifo_pop   = 1'b0;
    sclk_dly_next = sclk_reg;
    if (master_mode)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          sclk_next = 1'b0;
          if (fifo_valid && serial_mosi)
          begin
            // Bit 7 stands on the line a full half period before rising.
            fifo_pop   = 1'b1;
            tx_sh_next = fifo_data;
            div_next   = '0;
            bit_next   = '0;
            state_next = ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          div_next = div_reg + DW'(1);
          if (half_done)
          begin
            div_next   = '0;
            sclk_next  = 1'b1;
            rx_sh_next = {rx_sh_reg[WIDTH-2:0], miso_s};
            state_next = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          div_next = div_reg + DW'(1);
          if (half_done)
          begin
            div_next  = '0;
            sclk_next = 1'b0;
            if (bit_reg == BW'(WIDTH - 1))
            begin
              rx_next    = '{valid: 1'b1, data: rx_sh_reg};
              state_next = ST_IDLE;
            end
            else
            begin
              tx_sh_next = {tx_sh_reg[WIDTH-2:0], 1'b0};
              bit_next   = bit_reg + BW'(1);
              state_next = ST_SETUP;
            end
          end
        end
        default:
        begin
          state_next = ST_IDLE;
        end
      endcase
    end
    else
    begin
      sclk_next = 1'b0;
      div_next  = '0;
      case (state_reg)
        ST_IDLE:
        begin
          if (slave_selected)
          begin
            fifo_pop   = fifo_valid;
            tx_sh_next = load_word;
            bit_next   = '0;
            state_next = ST_SETUP;
          end
        end
        ST_SETUP, ST_HOLD:
        begin
          if (!slave_selected)
          begin
            state_next = ST_IDLE;
          end
          else if (sclk_rise)
          begin
            rx_sh_next = {rx_sh_reg[WIDTH-2:0], mosi_s};
            bit_next   = bit_reg + BW'(1);
            state_next = ST_HOLD;
            if (bit_reg == BW'(WIDTH - 1))
            begin
              rx_next  = '{valid: 1'b1,
                           data: {rx_sh_reg[WIDTH-2:0], mosi_s}};
              bit_next = '0;
            end
          end
          else if (sclk_fall && state_reg == ST_HOLD)
          begin
            state_next = ST_SETUP;
            if (bit_reg == '0)
            begin
              fifo_pop   = fifo_valid;
              tx_sh_next = load_word;
            end
            else
            begin
              tx_sh_next = {tx_sh_reg[WIDTH-2:0], 1'b0};
            end
          end
        end
        default:
        begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      div_reg   <= '0;
      bit_reg   <= '0;
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
      sclk_reg  <= 1'b0;
      sclk_dly_reg <= 1'b0;
      rx_reg    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      div_reg   <= div_next;
      bit_reg   <= bit_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      sclk_reg  <= sclk_next;
      sclk_dly_reg <= sclk_dly_next;
      rx_reg    <= rx_next;
    end
  end

  // The clock pin lags one cycle to stay in step with the registered data
  // pins, so each bit leads its sampling edge by a full half period.
  assign sclk_out = sclk_dly_reg;
  assign rx_word  = rx_reg;
  assign busy     = (state_reg != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers: serial function or port line per pin.

  pin_drive_t [PIN_COUNT-1:0] serial_drv;
  pin_drive_t [PIN_COUNT-1:0] drv_reg;
  pin_drive_t [PIN_COUNT-1:0] drv_next;
  logic       [2:0]           port_in_reg;
  logic       [2:0]           port_in_next;

  always_comb
  begin
    serial_drv[PIN_MOSI] = '{out: tx_sh_reg[WIDTH-1],
                             oe_n: !master_mode};
    // Master-in is driven only by a selected, active slave.
    serial_drv[PIN_MISO] = '{out: tx_sh_reg[WIDTH-1],
                             oe_n: master_mode || !slave_selected
                                   || state_reg == ST_IDLE};
    serial_drv[PIN_SS]   = '{out: 1'b1, oe_n: 1'b1};
    port_in_next         = {ss_n_s, miso_s, mosi_s};
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      assign drv_next[gi] = func_port_reg[gi]
        ? pin_drive_t'{out: port_line_out[gi],
                       oe_n: !port_line_dir_out[gi]}
        : serial_drv[gi];
    end
  endgenerate

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drv_reg     <= {PIN_COUNT{2'h1}};
      port_in_reg <= 3'h7;
    end
    else
    begin
      drv_reg     <= drv_next;
      port_in_reg <= port_in_next;
    end
  end

  assign port0_master_out_data_drv = drv_reg[PIN_MOSI];
  assign port0_master_in_data_drv  = drv_reg[PIN_MISO];
  assign port0_slave_select_n_drv  = drv_reg[PIN_SS];
  assign port_line_in              = port_in_reg;

endmodule

`default_nettype wire

// file: tb/spi_pins_props.sv
// Checker of pin drive, pull-up and transfer timing at the block ports.
`default_nettype none
module spi_pins_props
  import spi_pins_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       master_mode,
  input wire logic       sclk_out,
  input wire pin_drive_t port0_master_out_data_drv,
  input wire pin_drive_t port0_master_in_data_drv,
  input wire logic       port0_slave_select_n_in,
  input wire pin_drive_t port0_slave_select_n_drv,
  input wire logic [2:0] pin_pullup_on,
  input wire logic [7:0] port_e_pullup_enable,
  input wire logic [2:0] pin_func_is_port,
  input wire logic [2:0] port_line_dir_out,
  input wire logic [2:0] port_line_out,
  input wire rx_word_t   rx_word,
  input wire logic       busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic       mo_oe = port0_master_out_data_drv.oe_n;
  wire logic       mo_d  = port0_master_out_data_drv.out;
  wire logic       mi_oe = port0_master_in_data_drv.oe_n;
  wire logic [2:0] pe3   = {port_e_pullup_enable[PU_BIT_SS],
    port_e_pullup_enable[PU_BIT_MISO], port_e_pullup_enable[PU_BIT_MOSI]};
  sequence desel_s;
    (!master_mode && port0_slave_select_n_in && !pin_func_is_port[1]) [*6];
  endsequence
  sequence sclk_high_s;
    sclk_out [*4] ##1 !sclk_out;
  endsequence

  a_reset_pins_off: assert property (disable iff (1'b0)
    rst |-> mo_oe && mi_oe && port0_slave_select_n_drv.oe_n
      && pin_pullup_on == 3'h7) else $error("pins active in reset");
  a_pullup_follow: assert property (
    1'b1 |=> pin_pullup_on == $past(pe3)) else $error("pull-up wrong");
  a_ss_never_drv: assert property (
    !pin_func_is_port[2] [*3] |-> port0_slave_select_n_drv.oe_n)
    else $error("select pin driven");
  a_slave_mosi_in: assert property (
    (!master_mode && !pin_func_is_port[0]) [*3] |-> mo_oe)
    else $error("slave drives master-out");
  a_master_mosi_out: assert property (
    master_mode && !pin_func_is_port[0] && $rose(busy) |=> !mo_oe)
    else $error("master-out not driven");
  a_master_miso_in: assert property (
    (master_mode && !pin_func_is_port[1]) [*3] |-> mi_oe)
    else $error("master drives master-in");
  a_desel_miso_z: assert property (
    desel_s |-> mi_oe) else $error("deselected slave drives master-in");
  a_mosi_half_lead: assert property (
    master_mode && $rose(sclk_out) |-> sclk_high_s
      and ($past(mo_d, 4) == mo_d)) else $error("master-out bit late");
  a_master_byte_len: assert property (
    master_mode && $rose(busy) |-> ##64 rx_word.valid)
    else $error("master byte not received in time");
  a_port_line_out: assert property (
    (pin_func_is_port[0] && port_line_dir_out[0]
      && $stable(port_line_out[0])) [*3]
      |-> !mo_oe && mo_d == port_line_out[0]) else $error("port line wrong");
endmodule

bind spi_data_select_pins spi_pins_props i_spi_pins_props (.*);
`default_nettype wire

// file: tb/spi_peer_model.sv
// Far-side serial peer: slave to the block, or its master through xfer.
`default_nettype none
module spi_peer_model
(
  input  wire logic       sclk_from_dut,
  input  wire logic       mosi_pin,
  input  wire logic       miso_pin,
  input  wire logic       as_slave,
  input  wire logic [7:0] reply,
  output logic            sclk,
  output logic            ss_n,
  output logic            mosi_o,
  output logic            mosi_oe,
  output logic            miso_o,
  output logic      [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'hFF;
  initial
  begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi_o = 1'b1;
    mosi_oe = 1'b0;
    got = 8'h00;
  end
  assign miso_o = sh[7];
  always @(posedge as_slave) sh = reply;
  always @(posedge sclk_from_dut)
    if (as_slave) got = {got[6:0], mosi_pin};
  always @(negedge sclk_from_dut)
    if (as_slave) sh = {sh[6:0], 1'b1};
  // Master role: the clock stays low outside the frame.
  task automatic xfer(input logic [7:0] b);
    ss_n = 1'b0;
    #800;
    for (int i = 7; i >= 0; i--)
    begin
      mosi_oe = 1'b1;
      mosi_o = b[i];
      #400 sclk = 1'b1;
      got = {got[6:0], miso_pin};
      #400 sclk = 1'b0;
    end
    #400 mosi_oe = 1'b0;
    ss_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the serial data and select pin block.
`default_nettype none
module tb_top
  import spi_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst, master_mode, sclk_in, sclk_out, tx_valid, tx_ready;
  logic       busy, as_slave, ss_n, mosi_o, mosi_oe, miso_o;
  logic [7:0] port_e_pullup_enable, tx_data, reply, got, last_rx = 8'h00;
  logic [2:0] pin_pullup_on, pin_func_is_port, port_line_dir_out;
  logic [2:0] port_line_out, port_line_in;
  pin_drive_t port0_master_out_data_drv, port0_master_in_data_drv;
  pin_drive_t port0_slave_select_n_drv;
  rx_word_t   rx_word;
  int         n_fail = 0, samples_checked = 0, n_rx = 0;
  wire logic mosi_pin = !port0_master_out_data_drv.oe_n ?
    port0_master_out_data_drv.out : mosi_oe ? mosi_o : pin_pullup_on[0];
  wire logic miso_pin = !port0_master_in_data_drv.oe_n ?
    port0_master_in_data_drv.out : as_slave ? miso_o : pin_pullup_on[1];
  wire logic ss_pin = !port0_slave_select_n_drv.oe_n ?
    port0_slave_select_n_drv.out : ss_n;

  spi_data_select_pins i_spi_data_select_pins (
    .clk, .rst, .master_mode, .sclk_in, .sclk_out,
    .port0_master_out_data_in(mosi_pin), .port0_master_out_data_drv,
    .port0_master_in_data_in(miso_pin), .port0_master_in_data_drv,
    .port0_slave_select_n_in(ss_pin), .port0_slave_select_n_drv,
    .pin_pullup_on, .port_e_pullup_enable, .pin_func_is_port,
    .port_line_dir_out, .port_line_out, .port_line_in, .tx_valid,
    .tx_ready, .tx_data, .rx_word, .busy);
  spi_peer_model i_spi_peer_model (.sclk_from_dut(sclk_out), .mosi_pin,
    .miso_pin, .as_slave, .reply, .sclk(sclk_in), .ss_n, .mosi_o, .mosi_oe,
    .miso_o, .got);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (rx_word.valid === 1'b1)
    begin
      last_rx <= rx_word.data;
      n_rx <= n_rx + 1;
    end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic push_n(input logic [7:0] base, input int n);
    tx_valid = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      tx_data = 8'(base + i);
      tick();
    end
    tx_valid = 1'b0;
  endtask
  task automatic wait_rx(input int target);
    for (int k = 0; k < 300 && n_rx < target; k++)
      tick();
    chk("rx count", 8'(target), 8'(n_rx));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("mosi drive in reset", 8'h01, 8'(port0_master_out_data_drv));
    chk("pull-ups in reset", 8'h07, 8'(pin_pullup_on));
    rst = 1'b0;
    port_e_pullup_enable = 8'hA0;
    tick(3);
    chk("pull-ups A0", 8'h05, 8'(pin_pullup_on));
    chk("mosi in after reset", 8'h01,
        8'(port0_master_out_data_drv.oe_n));
    port_e_pullup_enable = 8'h40;
    tick(2);
    chk("pull-ups 40", 8'h02, 8'(pin_pullup_on));
  endtask
  task automatic t_slave();
    logic [7:0] w;
    push_n(8'h11, 5);
    chk("ready when full", 8'h00, 8'(tx_ready));
    for (int i = 0; i < 5; i++)
    begin
      // The word loaded at a byte's last fall is dropped when select ends.
      w = (i == 0) ? 8'h11 : (i == 1) ? 8'h13 : IDLE_FILL;
      i_spi_peer_model.xfer(8'(8'hC0 + i));
      tick(6);
      chk("slave sent", w, got);
      chk("slave took", 8'(8'hC0 + i), last_rx);
      chk("miso released", 8'h01,
          8'(port0_master_in_data_drv.oe_n));
    end
  endtask
  task automatic t_master();
    master_mode = 1'b1;
    reply = 8'h96;
    as_slave = 1'b1;
    tick(3);
    push_n(8'hA5, 2);
    wait_rx(6);
    chk("master took", 8'h96, last_rx);
    chk("peer took", 8'hA5, got);
    wait_rx(7);
    chk("master took 2", 8'hFF, last_rx);
    chk("peer took 2", 8'hA6, got);
  endtask
  task automatic t_port();
    master_mode = 1'b0;
    as_slave = 1'b0;
    port_e_pullup_enable = 8'hE0;
    port_line_dir_out = 3'h1;
    pin_func_is_port = 3'h3;
    tick(4);
    chk("port drive", 8'h00, 8'(port0_master_out_data_drv));
    chk("port miso in", 8'h01,
        8'(port0_master_in_data_drv.oe_n));
    tick(3);
    chk("port line in", 8'h00, 8'(port_line_in[0]));
    pin_func_is_port = 3'h0;
    tick(6);
    chk("serial again", 8'h01, 8'(port0_master_out_data_drv.oe_n));
    chk("pulled up", 8'h01, 8'(port_line_in[0]));
  endtask

  initial
  begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    rst = 1'b1;
    master_mode = 1'b0;
    as_slave = 1'b0;
    reply = 8'h00;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    port_e_pullup_enable = 8'hE0;
    pin_func_is_port = 3'h0;
    port_line_dir_out = 3'h0;
    port_line_out = 3'h0;
    tick(4);
    t_reset();
    t_slave();
    t_master();
    t_port();
    end_of_test();
  end
endmodule
`default_nettype wire
